// File: bench/ccm_osc_model.sv
// external oscillator model with separate high and low times
`timescale 1ns/1ps

module ccm_osc_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [5:0] hi_i,
    input wire logic [5:0] lo_i,
    output logic osc_o = 1'b0
);
    logic [5:0] cnt = 6'h0;

    // toggles after the high or low time; a dead crystal holds its level
    always @(posedge clk_i) begin
        if (!run_i) begin
            cnt <= 6'h0;
        end else if (cnt + 6'h1 >= (osc_o ? hi_i : lo_i)) begin
            cnt <= 6'h0;
            osc_o <= #1 ~osc_o;
        end else begin
            cnt <= cnt + 6'h1;
        end
    end
endmodule : ccm_osc_model

// File: bench/ccm_top_bench.sv
// self-checking bench for the cpu clock mode selector and watchdog
`timescale 1ns/1ps
`include "ccm_cfg.svh"

module ccm_top_bench;
    import ccm_pkg::*;
    typedef struct {string what; int lo; int hi;} ccm_note_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic tick = 1'b0;
    logic run = 1'b1;
    logic follow = 1'b0;
    logic prev = 1'b0;
    logic [1:0] tcnt = 2'h0;
    logic [2:0] straps = 3'h7;
    logic [15:0] cfg = 16'h0;
    logic [5:0] osc_hi = 6'h10;
    logic [5:0] osc_lo = 6'h10;
    logic osc, cpu_clock, cpu_edge, irq, loop_on;
    logic [2:0] mode;
    logic [15:0] edges = 16'h0;
    logic [15:0] ferr = 16'h0;
    logic [15:0] base = 16'h0;
    logic [15:0] act;
    int fails = 0;
    int samples_checked = 0;
    int seed = 32'h3c318814;
    int f2 [8] = '{`CCM_F2_X2P5, `CCM_F2_X0P5, `CCM_F2_X1P5, `CCM_F2_X1,
                   `CCM_F2_X5, `CCM_F2_X2, `CCM_F2_X3, `CCM_F2_X4};
    ccm_note_t notes [$];
    ccm_note_t n;
    event look;
    event open;

    ccm_osc_model osc_m (.clk_i(clk_i), .run_i(run), .hi_i(osc_hi), .lo_i(osc_lo),
                         .osc_o(osc));
    ccm_top uut (.clk_i(clk_i), .rst_i(rst_i), .clock_mode_straps_i(straps),
                 .clock_input_pin_i(osc), .loop_tick_i(tick),
                 .system_config_register_i(cfg), .cpu_clock_o(cpu_clock),
                 .cpu_edge_o(cpu_edge), .osc_fail_irq_o(irq), .loop_on_o(loop_on),
                 .clock_mode_o(mode));

    // 40 MHz system clock
    always #12.5 clk_i = ~clk_i;

    // free-running loop clock: one tick every four system cycles
    always @(posedge clk_i) begin
        tcnt <= tcnt + 2'h1;
        tick <= #1 (tcnt == 2'h3);
    end

    // counts cpu clock edges and direct-drive tracking slips
    always @(posedge clk_i) begin
        prev <= osc;
        if (cpu_edge === 1'b1) edges <= edges + 16'h1;
        if (follow && cpu_clock !== prev) ferr <= ferr + 16'h1;
    end

    // opens an edge-count window
    always @(open) base = edges;

    // picks the observed value that a note refers to
    function automatic logic [15:0] pick(input string w);
        case (w)
            "mode": return {13'h0, mode};
            "irq": return {15'h0, irq};
            "loop_on": return {15'h0, loop_on};
            "cpu_clock": return {15'h0, cpu_clock};
            "ferr": return ferr;
            default: return edges - base;
        endcase
    endfunction : pick

    // takes the oldest note whenever a result is offered and compares
    always @(look) begin
        n = notes.pop_front();
        act = pick(n.what);
        samples_checked++;
        if ((act >= n.lo && act <= n.hi) !== 1'b1) begin
            $display("Error %s expected %0d to %0d seen %0d", n.what, n.lo, n.hi, act);
            fails++;
        end
    end

    // notes an expected range and offers the result at the falling edge
    task automatic check(input string w, input int lo, input int hi);
        @(negedge clk_i);
        notes.push_back('{w, lo, hi});
        -> look;
    endtask : check

    // resets with a mode code and watchdog disable level, then scrambles straps
    task automatic restart(input logic [2:0] code, input logic dis);
        @(posedge clk_i);
        #1 rst_i = 1'b1;
        straps = code;
        cfg = $random(seed);
        cfg[`CCM_WD_DIS_BIT] = dis;
        repeat (8) @(posedge clk_i);
        check("mode", 7, 7);
        check("cpu_clock", 0, 0);
        check("irq", 0, 0);
        check("loop_on", 0, 0);
        @(posedge clk_i);
        #1 rst_i = 1'b0;
        @(posedge clk_i);
        #1 straps = $random(seed);
        repeat (3) @(posedge clk_i);
    endtask : restart

    // stops the oscillator just after one of its transitions
    task automatic kill_osc();
        @(osc);
        @(posedge clk_i);
        #1 run = 1'b0;
    endtask : kill_osc

    // prints the counts and the verdict, then ends the run
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // watchdog: the tests need under 4000 cycles, allow five times that
    initial begin
        #500000;
        fails++;
        results();
    end

    // main sequence
    initial begin
        for (int c = 0; c < 8; c++) begin
            osc_hi = (c == 3) ? 6'ha : 6'h10;
            osc_lo = (c == 3) ? 6'h16 : 6'h10;
            restart(c[2:0], 1'b0);
            check("mode", c, c);
            check("loop_on", 1, 1);
            repeat (128) @(posedge clk_i);
            #1 -> open;
            follow = (c == 3);
            repeat (256) @(posedge clk_i);
            #1 follow = 1'b0;
            check("edges", f2[c] * 7, f2[c] * 9);
            if (c == 1 || c == 3) check("edges", f2[c] * 8 - 1, f2[c] * 8 + 1);
            check("ferr", 0, 0);
            check("mode", c, c);
            check("irq", 0, 0);
            $display("mode %0d test done", c);
        end
        restart(3'h3, 1'b0);
        kill_osc();
        repeat (15) @(posedge tick);
        check("irq", 0, 0);
        repeat (2) @(posedge tick);
        repeat (2) @(posedge clk_i);
        check("irq", 1, 1);
        #1 run = 1'b1;
        -> open;
        repeat (80) @(posedge clk_i);
        check("edges", 19, 21);
        check("irq", 1, 1);
        restart(3'h3, 1'b0);
        #1 -> open;
        repeat (64) @(posedge clk_i);
        check("edges", 3, 5);
        $display("failover test done");
        restart(3'h3, 1'b1);
        check("loop_on", 0, 0);
        kill_osc();
        -> open;
        repeat (120) @(posedge clk_i);
        check("irq", 0, 0);
        check("edges", 0, 1);
        #1 run = 1'b1;
        $display("disabled watchdog test done");
        results();
    end
endmodule : ccm_top_bench

// File: rtl/ccm_top.sv
// cpu clock mode selection with prescaler, direct drive, multiplier and watchdog
`timescale 1ns/1ps
`include "ccm_cfg.svh"

module ccm_top
    import ccm_pkg::*;
#(
    parameter int PER_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] clock_mode_straps_i,
    input wire logic clock_input_pin_i,
    input wire logic loop_tick_i,
    input wire logic [`CCM_SYSCFG_W-1:0] system_config_register_i,
    output logic cpu_clock_o,
    output logic cpu_edge_o,
    output logic osc_fail_irq_o,
    output logic loop_on_o,
    output logic [2:0] clock_mode_o
);

    ccm_src_t src;
    ccm_src_t next_src;
    logic captured;
    logic [2:0] mode;
    logic in_prev;
    logic cpu_clock;
    logic next_cpu;
    logic [PER_W-1:0] pcnt;
    logic [PER_W-1:0] tper;
    logic [PER_W-1:0] tlock;
    logic [PER_W:0] acc;
    logic [3:0] tcnt;

    ccm_wd_if wd_bus (.clk(clk_i), .rst(rst_i));

    ccm_watchdog u_watchdog (.wd(wd_bus));

    // input clock transitions and mode decode
    wire in_rise = clock_input_pin_i && !in_prev;
    wire in_tog = clock_input_pin_i ^ in_prev;
    wire [3:0] f2 = ccm_factor2(mode);
    wire osc_watchdog_disable = system_config_register_i[`CCM_WD_DIS_BIT];
    wire wd_en = captured && !osc_watchdog_disable && (src != CCM_SRC_FREERUN);
    wire fail_now = wd_en && wd_bus.overflow;

    // watchdog hookup: loop ticks count, input transitions clear
    assign wd_bus.enable = wd_en;
    assign wd_bus.tick = loop_tick_i;
    assign wd_bus.clear = in_tog;

    // multiplier: f2 cpu edges per measured input period
    wire [PER_W:0] acc_sum = acc + {{(PER_W-3){1'b0}}, f2};
    wire nco_hit = (tlock != '0) && (acc_sum >= {1'b0, tlock});
    wire resync = in_tog && (tcnt >= f2 - 4'h1);
    wire pcnt_max = (pcnt == {PER_W{1'b1}});

    // strap capture on the first edge after reset release
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            captured <= 1'b0;
            mode <= `CCM_MODE_RESET;
        end else if (!captured) begin
            captured <= 1'b1;
            mode <= clock_mode_straps_i;
        end
    end

    // source selection; failover is sticky until reset
    always_comb begin
        next_src = src;
        case (src)
            CCM_SRC_BOOT: begin
                next_src = ccm_src_of(clock_mode_straps_i);
            end
            CCM_SRC_PLL, CCM_SRC_PRESCALE, CCM_SRC_DIRECT: begin
                if (fail_now) begin
                    next_src = CCM_SRC_FREERUN;
                end
            end
            CCM_SRC_FREERUN: begin
                next_src = CCM_SRC_FREERUN;
            end
            default: begin
                next_src = CCM_SRC_BOOT;
            end
        endcase
    end

    // cpu clock level per source; loop failover starts from the held level
    always_comb begin
        next_cpu = cpu_clock;
        case (src)
            CCM_SRC_PLL: next_cpu = cpu_clock ^ nco_hit;
            CCM_SRC_PRESCALE: next_cpu = cpu_clock ^ in_rise;
            CCM_SRC_DIRECT: next_cpu = clock_input_pin_i;
            CCM_SRC_FREERUN: next_cpu = cpu_clock ^ loop_tick_i;
            default: next_cpu = cpu_clock;
        endcase
    end

    // source state and cpu clock outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            src <= CCM_SRC_BOOT;
            cpu_clock <= 1'b0;
            cpu_edge_o <= 1'b0;
        end else begin
            src <= next_src;
            cpu_clock <= next_cpu;
            cpu_edge_o <= (next_cpu != cpu_clock);
        end
    end

    assign cpu_clock_o = cpu_clock;

    // failure request and loop power, both registered
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_fail_irq_o <= 1'b0;
            loop_on_o <= 1'b0;
            clock_mode_o <= `CCM_MODE_RESET;
            in_prev <= 1'b0;
        end else begin
            osc_fail_irq_o <= osc_fail_irq_o || fail_now;
            loop_on_o <= (next_src == CCM_SRC_PLL) || (next_src == CCM_SRC_FREERUN)
                         || (captured && !osc_watchdog_disable);
            clock_mode_o <= captured ? mode : clock_mode_straps_i;
            in_prev <= clock_input_pin_i;
        end
    end

    // input period measurement in system clocks
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pcnt <= '0;
            tper <= '0;
        end else if (in_rise) begin
            pcnt <= '0;
            tper <= pcnt + {{(PER_W-1){1'b0}}, 1'b1};
        end else if (!pcnt_max) begin
            pcnt <= pcnt + {{(PER_W-1){1'b0}}, 1'b1};
        end
    end

    // resynchronise the loop period every f2 input transitions
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tcnt <= 4'h0;
            tlock <= '0;
        end else if (resync) begin
            tcnt <= 4'h0;
            tlock <= tper;
        end else if (in_tog) begin
            tcnt <= tcnt + 4'h1;
        end
    end

    // phase accumulator keeps its residue, so a new period bends smoothly
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc <= '0;
        end else if (src != CCM_SRC_PLL) begin
            acc <= '0;
        end else if (nco_hit) begin
            acc <= acc_sum - {1'b0, tlock};
        end else if (tlock != '0) begin
            acc <= acc_sum;
        end
    end

    a_mode_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
        captured |=> (mode == $past(mode)))
        else $error("mode changed after capture");

    a_boot_select: assert property (@(posedge clk_i) disable iff (rst_i)
        (src == CCM_SRC_BOOT) |=> (src == ccm_src_of($past(clock_mode_straps_i)))
            && (mode == $past(clock_mode_straps_i)))
        else $error("source not chosen from captured straps");

    a_edge_event: assert property (@(posedge clk_i) disable iff (rst_i)
        cpu_edge_o == (cpu_clock_o != $past(cpu_clock_o)))
        else $error("edge event does not match cpu clock change");

    a_prescale_phase: assert property (@(posedge clk_i) disable iff (rst_i)
        (src == CCM_SRC_PRESCALE) |=> ((cpu_clock_o != $past(cpu_clock_o)) == $past(in_rise)))
        else $error("prescaled clock did not toggle on input rise only");

    a_direct_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        (src == CCM_SRC_DIRECT) |=> (cpu_clock_o == $past(clock_input_pin_i)))
        else $error("direct drive clock does not follow input");

    a_fail_switch: assert property (@(posedge clk_i) disable iff (rst_i)
        fail_now |=> (src == CCM_SRC_FREERUN) && osc_fail_irq_o ##1 osc_fail_irq_o)
        else $error("failure did not switch source and raise request");

    a_freerun_held: assert property (@(posedge clk_i) disable iff (rst_i)
        (src == CCM_SRC_FREERUN) |=> (src == CCM_SRC_FREERUN) && osc_fail_irq_o)
        else $error("failover released without reset");

    a_freerun_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        (src == CCM_SRC_FREERUN) |=> ((cpu_clock_o != $past(cpu_clock_o)) == $past(loop_tick_i)))
        else $error("loop clock phase not whole after failover");

    a_loop_off: assert property (@(posedge clk_i) disable iff (rst_i)
        (captured && osc_watchdog_disable
            && (next_src == CCM_SRC_DIRECT || next_src == CCM_SRC_PRESCALE))
            |=> !loop_on_o)
        else $error("loop left powered with watchdog disabled");

    a_pll_rate: assert property (@(posedge clk_i) disable iff (rst_i)
        (src == CCM_SRC_PLL) |=> ((cpu_clock_o != $past(cpu_clock_o)) == $past(nco_hit)))
        else $error("multiplier output not driving cpu clock");

endmodule : ccm_top

// File: rtl/ccm_watchdog.sv
// oscillator watchdog counter, stepped by the free-running loop clock
`timescale 1ns/1ps
`include "ccm_cfg.svh"

module ccm_watchdog
    import ccm_pkg::*;
(
    ccm_wd_if.unit wd
);

    logic [4:0] count;
    logic at_ovf;

    // overflow once the full count of loop cycles passed without a transition
    assign at_ovf = (count == `CCM_WD_OVF_TICKS);
    assign wd.count = count;
    assign wd.overflow = at_ovf;

    // transition clear beats a loop tick in the same cycle
    always_ff @(posedge wd.clk or posedge wd.rst) begin
        if (wd.rst) begin
            count <= 5'h00;
        end else if (!wd.enable || wd.clear) begin
            count <= 5'h00;
        end else if (wd.tick && !at_ovf) begin
            count <= count + 5'h01;
        end
    end

    a_wd_clear_zero: assert property (@(posedge wd.clk) disable iff (wd.rst)
        (wd.enable && wd.clear) |=> (count == 5'h00))
        else $error("watchdog count not cleared by input transition");

    a_wd_tick_step: assert property (@(posedge wd.clk) disable iff (wd.rst)
        (wd.enable && !wd.clear && wd.tick && !at_ovf) |=> (count == $past(count) + 5'h01))
        else $error("watchdog count did not follow a loop tick");

    a_wd_ovf_sixteen: assert property (@(posedge wd.clk) disable iff (wd.rst)
        $rose(at_ovf) |-> ($past(count) == 5'h0f) && $past(wd.tick))
        else $error("watchdog overflow not after sixteen loop ticks");

endmodule : ccm_watchdog

// File: shared/ccm_cfg.svh
// constants for the cpu clock mode selector and oscillator watchdog
`ifndef CCM_CFG_SVH
`define CCM_CFG_SVH

// clock mode straps codes
`define CCM_CODE_X4 3'h7
`define CCM_CODE_X3 3'h6
`define CCM_CODE_X2 3'h5
`define CCM_CODE_X5 3'h4
`define CCM_CODE_DIRECT 3'h3
`define CCM_CODE_X1P5 3'h2
`define CCM_CODE_PRESCALE 3'h1
`define CCM_CODE_X2P5 3'h0

// mode held before the straps are captured (default configuration)
`define CCM_MODE_RESET 3'h7

// cpu clock edges per input clock period, i.e. twice the factor
`define CCM_F2_X4 4'h8
`define CCM_F2_X3 4'h6
`define CCM_F2_X2 4'h4
`define CCM_F2_X5 4'ha
`define CCM_F2_X1 4'h2
`define CCM_F2_X1P5 4'h3
`define CCM_F2_X0P5 4'h1
`define CCM_F2_X2P5 4'h5

// system configuration register width and watchdog disable bit
`define CCM_SYSCFG_W 16
`define CCM_WD_DIS_BIT 4

// loop clock cycles without an input transition before overflow
`define CCM_WD_OVF_TICKS 5'h10

// system clock rate
`define CCM_CLK_MHZ 40

`endif

// File: shared/ccm_pkg.sv
// types and mode decoding for the cpu clock mode selector
`include "ccm_cfg.svh"

package ccm_pkg;

    // where the cpu clock currently comes from
    typedef enum logic [2:0] {
        CCM_SRC_BOOT,
        CCM_SRC_PLL,
        CCM_SRC_PRESCALE,
        CCM_SRC_DIRECT,
        CCM_SRC_FREERUN
    } ccm_src_t;

    // cpu clock edges per input period for a mode code
    function automatic logic [3:0] ccm_factor2(input logic [2:0] code);
        logic [3:0] f2;
        f2 = `CCM_F2_X4;
        case (code)
            `CCM_CODE_X4: f2 = `CCM_F2_X4;
            `CCM_CODE_X3: f2 = `CCM_F2_X3;
            `CCM_CODE_X2: f2 = `CCM_F2_X2;
            `CCM_CODE_X5: f2 = `CCM_F2_X5;
            `CCM_CODE_DIRECT: f2 = `CCM_F2_X1;
            `CCM_CODE_X1P5: f2 = `CCM_F2_X1P5;
            `CCM_CODE_PRESCALE: f2 = `CCM_F2_X0P5;
            default: f2 = `CCM_F2_X2P5;
        endcase
        return f2;
    endfunction : ccm_factor2

    // clock source selected by a mode code
    function automatic ccm_src_t ccm_src_of(input logic [2:0] code);
        ccm_src_t s;
        s = CCM_SRC_PLL;
        if (code == `CCM_CODE_PRESCALE) begin
            s = CCM_SRC_PRESCALE;
        end else if (code == `CCM_CODE_DIRECT) begin
            s = CCM_SRC_DIRECT;
        end
        return s;
    endfunction : ccm_src_of

endpackage : ccm_pkg

// File: shared/ccm_wd_if.sv
// signals between the clock selector and its watchdog counter
`timescale 1ns/1ps

interface ccm_wd_if (
    input wire logic clk,
    input wire logic rst
);
    logic enable;
    logic tick;
    logic clear;
    logic [4:0] count;
    logic overflow;

    modport unit (input clk, input rst, input enable, input tick, input clear,
                  output count, output overflow);
    modport ctl (input clk, input rst, input count, input overflow,
                 output enable, output tick, output clear);
endinterface : ccm_wd_if
